/* src/spc_pkg.sv */
package spc_pkg;

	localparam int          SPC_ADDR_W       = 8;
	localparam logic [4:0]  SPC_IDX_MAC_CTL  = 5'h10;
	localparam logic [4:0]  SPC_IDX_MAC_STS  = 5'h11;
	localparam logic [4:0]  SPC_IDX_MAC_ADV  = 5'h12;
	localparam logic [4:0]  SPC_IDX_MAC_LP   = 5'h13;
	localparam logic [4:0]  SPC_IDX_MAC_SDS  = 5'h14;
	localparam logic [4:0]  SPC_IDX_TX_GOOD  = 5'h15;
	localparam logic [4:0]  SPC_IDX_TX_CRC   = 5'h16;
	localparam logic [4:0]  SPC_IDX_MED_CTL  = 5'h17;
	localparam logic [4:0]  SPC_IDX_MED_STS  = 5'h18;
	localparam logic [4:0]  SPC_IDX_MED_ADV  = 5'h19;

	// field positions
	localparam int          SPC_BIT_FORCE_ADV  = 11;
	localparam int          SPC_BIT_MAC_ODD    = 2;
	localparam int          SPC_BIT_SYNC_FAIL  = 15;
	localparam int          SPC_BIT_CG_BAD     = 14;
	localparam int          SPC_BIT_REALIGN    = 15;
	localparam int          SPC_BIT_SIG_DET    = 14;
	localparam int          SPC_BIT_QSGMII     = 13;
	localparam int          SPC_BIT_COMMA      = 12;
	localparam int          SPC_BIT_CNT_ACTIVE = 15;
	localparam int          SPC_BIT_TX_SEL     = 14;
	localparam int          SPC_BIT_MED_RF     = 14;
	localparam int          SPC_BIT_MED_PD     = 13;
	localparam int          SPC_BIT_POL_IN     = 6;
	localparam int          SPC_BIT_POL_OUT    = 5;
	localparam int          SPC_BIT_MED_ODD    = 4;
	localparam int          SPC_BIT_FX_HLS     = 2;
	localparam int          SPC_BIT_FEFI_FORCE = 1;
	localparam int          SPC_BIT_FEFI_VAL   = 0;

	// reset values
	localparam logic [15:0] SPC_RST_ADV      = 16'h0000;
	localparam logic        SPC_RST_ODD_INH  = 1'b1;
	localparam logic        SPC_RST_COMMA    = 1'b1;
	localparam logic [1:0]  SPC_RST_TX_SEL   = 2'h0;

	localparam logic [1:0]  SPC_SEL_MEDIA    = 2'h0;
	localparam logic [1:0]  SPC_SEL_MAC      = 2'h1;

	// counter limits
	localparam logic [13:0] SPC_GOOD_LAST    = 14'h270f;
	localparam logic [7:0]  SPC_CRC_MAX      = 8'hff;

endpackage

/* src/spc_bank.sv */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

module spc_bank
	import spc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [SPC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  mac_sync_lost,
	input  wire logic                  mac_cg_bad,
	input  wire logic                  mac_align_error,
	input  wire logic                  mac_lp_an_restart,
	input  wire logic [1:0]            mac_remote_fault,
	input  wire logic [3:0]            mac_adv_flags,
	input  wire logic                  mac_lp_an_capable,
	input  wire logic                  mac_link_up,
	input  wire logic                  mac_an_complete,
	input  wire logic                  mac_signal_detect,
	input  wire logic [15:0]           mac_auto_code_word,
	input  wire logic [15:0]           mac_rx_code_word,
	input  wire logic                  mac_rx_code_valid,
	input  wire logic                  mac_comma_realign,
	input  wire logic                  mac_serdes_sig_event,
	input  wire logic                  mac_qsgmii_sync,
	input  wire logic                  mac_comma_present,
	input  wire logic [3:0]            mac_comma_position,
	input  wire logic                  media_link_up,
	input  wire logic                  media_tx_good,
	input  wire logic                  media_tx_crc_err,
	input  wire logic                  mac_tx_good,
	input  wire logic                  mac_tx_crc_err,
	input  wire logic [1:0]            media_rf_sent,
	input  wire logic [15:0]           media_auto_code_word,
	input  wire logic                  media_fefi_auto,
	input  wire logic                  media_sync_lost,
	input  wire logic                  media_cg_bad,
	input  wire logic                  fx_link_100,
	input  wire logic                  link_10,
	input  wire logic                  media_lp_an_restart,
	input  wire logic [1:0]            media_lp_remote_fault,
	input  wire logic [3:0]            media_lp_adv_flags,
	input  wire logic                  media_lp_an_capable,
	input  wire logic                  media_an_complete,
	input  wire logic                  media_signal_detect,
	output logic [15:0]                mac_tx_code_word,
	output logic [15:0]                media_tx_code_word,
	output logic                       mac_odd_start_inhibit,
	output logic                       media_odd_start_inhibit,
	output logic                       media_pd_enable,
	output logic                       media_rx_invert,
	output logic                       media_tx_invert,
	output logic                       fx_force_hls,
	output logic                       fx_fefi_on
);

	typedef struct packed {
		logic        mac_force;
		logic        mac_odd_inh;
		logic [15:0] mac_adv;
		logic [15:0] mac_tx_word;
		logic [15:0] mac_lp_word;
		logic        mac_sync_fail;
		logic        mac_cg_flag;
		logic        mac_realign;
		logic        mac_sig_flag;
		logic        mac_comma;
		logic        media_force;
		logic        media_pd;
		logic        pol_in;
		logic        pol_out;
		logic        media_odd_inh;
		logic        hls;
		logic        fefi_force;
		logic        fefi_val;
		logic        fefi_on;
		logic [15:0] media_adv;
		logic [15:0] media_tx_word;
		logic        media_sync_fail;
		logic        media_cg_flag;
		logic [1:0]  tx_sel;
		logic        good_active;
		logic [13:0] good_cnt;
		logic [7:0]  crc_cnt;
		logic [31:0] rdata;
	} spc_state_type;

	spc_state_type state;
	spc_state_type next_state;

	function automatic logic [4:0] spc_index(input logic [SPC_ADDR_W-1:0] a);
		spc_index = a[6:2];
	endfunction

	// registers sit at four times their index; anything else is refused
	function automatic logic spc_mapped(input logic [SPC_ADDR_W-1:0] a);
		logic [4:0] idx;
		idx = a[6:2];
		spc_mapped = (a[1:0] == 2'h0) && (a[SPC_ADDR_W-1:7] == '0) &&
			(idx >= SPC_IDX_MAC_CTL) && (idx <= SPC_IDX_MED_ADV);
	endfunction

	// one decode of the select feeds both counters, so the paths cannot disagree
	function automatic logic spc_pick(
		input logic [1:0] sel,
		input logic       media_v,
		input logic       mac_v
	);
		spc_pick = (sel == SPC_SEL_MEDIA) ? media_v : mac_v;
	endfunction

	logic        setup;
	logic        access;
	logic        rd_hit;
	logic        wr_hit;
	logic [4:0]  idx;
	logic [15:0] rd_word;
	logic        cnt_enable;
	logic        good_pulse;
	logic        crc_pulse;

	// no wait states: every access, refused ones too, ends in one cycle
	assign pready  = 1'b1;
	// refused writes are dropped and refused reads return zero
	assign pslverr = psel && penable && !spc_mapped(paddr);
	assign prdata  = state.rdata;

	assign mac_tx_code_word        = state.mac_tx_word;
	assign media_tx_code_word      = state.media_tx_word;
	assign mac_odd_start_inhibit   = state.mac_odd_inh;
	assign media_odd_start_inhibit = state.media_odd_inh;
	assign media_pd_enable         = state.media_pd;
	assign media_rx_invert         = state.pol_in;
	assign media_tx_invert         = state.pol_out;
	assign fx_force_hls            = state.hls;
	assign fx_fefi_on              = state.fefi_on;

	always_comb
	begin
		setup      = psel && !penable;
		access     = psel && penable;
		idx        = spc_index(paddr);
		rd_hit     = access && !pwrite && spc_mapped(paddr);
		wr_hit     = access && pwrite && spc_mapped(paddr);
		cnt_enable = media_link_up &&
			(state.tx_sel == SPC_SEL_MEDIA || state.tx_sel == SPC_SEL_MAC);
		good_pulse = cnt_enable &&
			spc_pick(state.tx_sel, media_tx_good, mac_tx_good);
		crc_pulse  = cnt_enable &&
			spc_pick(state.tx_sel, media_tx_crc_err, mac_tx_crc_err);

		// live status levels are shown as sampled; only the named flags latch
		rd_word = 16'h0000;
		case (idx)
			SPC_IDX_MAC_CTL:
			begin
				rd_word[SPC_BIT_FORCE_ADV] = state.mac_force;
				rd_word[SPC_BIT_MAC_ODD]   = state.mac_odd_inh;
			end
			SPC_IDX_MAC_STS:
			begin
				rd_word[SPC_BIT_SYNC_FAIL] = state.mac_sync_fail;
				rd_word[SPC_BIT_CG_BAD]    = state.mac_cg_flag;
				rd_word[12]                = mac_align_error;
				rd_word[11]                = mac_lp_an_restart;
				rd_word[9:8]               = mac_remote_fault;
				rd_word[7:4]               = mac_adv_flags;
				rd_word[3]                 = mac_lp_an_capable;
				rd_word[2]                 = mac_link_up;
				rd_word[1]                 = mac_an_complete;
				rd_word[0]                 = mac_signal_detect;
			end
			SPC_IDX_MAC_ADV: rd_word = state.mac_tx_word;
			SPC_IDX_MAC_LP:  rd_word = state.mac_lp_word;
			SPC_IDX_MAC_SDS:
			begin
				rd_word[SPC_BIT_REALIGN] = state.mac_realign;
				rd_word[SPC_BIT_SIG_DET] = state.mac_sig_flag;
				rd_word[SPC_BIT_QSGMII]  = mac_qsgmii_sync;
				rd_word[SPC_BIT_COMMA]   = state.mac_comma;
				rd_word[11:8]            = mac_comma_position;
			end
			SPC_IDX_TX_GOOD:
			begin
				rd_word[SPC_BIT_CNT_ACTIVE] = state.good_active;
				rd_word[13:0]               = state.good_cnt;
			end
			SPC_IDX_TX_CRC:
			begin
				rd_word[15:14] = state.tx_sel;
				rd_word[7:0]   = state.crc_cnt;
			end
			SPC_IDX_MED_CTL:
			begin
				rd_word[15:14]              = media_rf_sent;
				rd_word[SPC_BIT_MED_PD]     = state.media_pd;
				rd_word[SPC_BIT_FORCE_ADV]  = state.media_force;
				rd_word[SPC_BIT_POL_IN]     = state.pol_in;
				rd_word[SPC_BIT_POL_OUT]    = state.pol_out;
				rd_word[SPC_BIT_MED_ODD]    = state.media_odd_inh;
				rd_word[SPC_BIT_FX_HLS]     = state.hls;
				rd_word[SPC_BIT_FEFI_FORCE] = state.fefi_force;
				rd_word[SPC_BIT_FEFI_VAL]   = state.fefi_val;
			end
			SPC_IDX_MED_STS:
			begin
				rd_word[SPC_BIT_SYNC_FAIL] = state.media_sync_fail;
				rd_word[SPC_BIT_CG_BAD]    = state.media_cg_flag;
				rd_word[13]                = fx_link_100;
				rd_word[12]                = link_10;
				rd_word[11]                = media_lp_an_restart;
				rd_word[9:8]               = media_lp_remote_fault;
				rd_word[7:4]               = media_lp_adv_flags;
				rd_word[3]                 = media_lp_an_capable;
				rd_word[2]                 = media_link_up;
				rd_word[1]                 = media_an_complete;
				rd_word[0]                 = media_signal_detect;
			end
			SPC_IDX_MED_ADV: rd_word = state.media_tx_word;
			default:         rd_word = 16'h0000;
		endcase

		next_state = state;

		// snapshot taken in the setup cycle; the access edge clears only the sticky flags it showed, and re-arms comma detect whatever it showed
		if (setup && !pwrite)
			next_state.rdata = spc_mapped(paddr) ? {16'h0000, rd_word} : 32'h0000_0000;

		if (wr_hit)
		begin
			case (idx)
				SPC_IDX_MAC_CTL:
				begin
					next_state.mac_force   = pwdata[SPC_BIT_FORCE_ADV];
					next_state.mac_odd_inh = pwdata[SPC_BIT_MAC_ODD];
				end
				SPC_IDX_MAC_ADV:
					if (state.mac_force)
						next_state.mac_adv = pwdata[15:0];
				SPC_IDX_TX_CRC:
					next_state.tx_sel = pwdata[15:14];
				SPC_IDX_MED_CTL:
				begin
					// parallel detect sanity is left to software
					next_state.media_pd      = pwdata[SPC_BIT_MED_PD];
					next_state.media_force   = pwdata[SPC_BIT_FORCE_ADV];
					next_state.pol_in        = pwdata[SPC_BIT_POL_IN];
					next_state.pol_out       = pwdata[SPC_BIT_POL_OUT];
					next_state.media_odd_inh = pwdata[SPC_BIT_MED_ODD];
					next_state.hls           = pwdata[SPC_BIT_FX_HLS];
					next_state.fefi_force    = pwdata[SPC_BIT_FEFI_FORCE];
					next_state.fefi_val      = pwdata[SPC_BIT_FEFI_VAL];
				end
				SPC_IDX_MED_ADV:
					if (state.media_force)
						next_state.media_adv = pwdata[15:0];
				default:
				begin
				end
			endcase
		end

		// event sets win over the read clear
		// an event at the setup edge of a read that already shows the flag
		// merges into that read's 1; a sticky bit counts no repeats anyway
		if (rd_hit && idx == SPC_IDX_MAC_STS)
		begin
			if (state.rdata[SPC_BIT_SYNC_FAIL])
				next_state.mac_sync_fail = 1'b0;
			if (state.rdata[SPC_BIT_CG_BAD])
				next_state.mac_cg_flag = 1'b0;
		end
		if (rd_hit && idx == SPC_IDX_MED_STS)
		begin
			if (state.rdata[SPC_BIT_SYNC_FAIL])
				next_state.media_sync_fail = 1'b0;
			if (state.rdata[SPC_BIT_CG_BAD])
				next_state.media_cg_flag = 1'b0;
		end
		if (rd_hit && idx == SPC_IDX_MAC_SDS)
		begin
			if (state.rdata[SPC_BIT_REALIGN])
				next_state.mac_realign = 1'b0;
			if (state.rdata[SPC_BIT_SIG_DET])
				next_state.mac_sig_flag = 1'b0;
			next_state.mac_comma = 1'b1;
		end
		if (mac_sync_lost)
			next_state.mac_sync_fail = 1'b1;
		if (mac_cg_bad)
			next_state.mac_cg_flag = 1'b1;
		if (media_sync_lost)
			next_state.media_sync_fail = 1'b1;
		if (media_cg_bad)
			next_state.media_cg_flag = 1'b1;
		if (mac_comma_realign)
			next_state.mac_realign = 1'b1;
		if (mac_serdes_sig_event)
			next_state.mac_sig_flag = 1'b1;
		if (!mac_comma_present)
			next_state.mac_comma = 1'b0;

		// partner word is kept until the next valid code word arrives
		if (mac_rx_code_valid)
			next_state.mac_lp_word = mac_rx_code_word;

		// sent word follows the forced value or the negotiation engine
		next_state.mac_tx_word   = next_state.mac_force ?
			next_state.mac_adv : mac_auto_code_word;
		next_state.media_tx_word = next_state.media_force ?
			next_state.media_adv : media_auto_code_word;

		next_state.fefi_on = next_state.fefi_force ?
			next_state.fefi_val : media_fefi_auto;

		// reserved select codes park both counters instead of guessing a path
		// good count wraps at the decimal modulus, not at the field width
		next_state.good_active = cnt_enable;
		if (good_pulse)
			next_state.good_cnt = (state.good_cnt == SPC_GOOD_LAST) ?
				14'h0000 : state.good_cnt + 14'h0001;
		if (crc_pulse && state.crc_cnt != SPC_CRC_MAX)
			next_state.crc_cnt = state.crc_cnt + 8'h01;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// inhibit bits and comma detect leave reset set, all else clear
			state               <= '0;
			state.mac_odd_inh   <= SPC_RST_ODD_INH;
			state.media_odd_inh <= SPC_RST_ODD_INH;
			state.mac_adv       <= SPC_RST_ADV;
			state.media_adv     <= SPC_RST_ADV;
			state.mac_comma     <= SPC_RST_COMMA;
			state.tx_sel        <= SPC_RST_TX_SEL;
		end
		else
		begin
			state <= next_state;
		end
	end

endmodule

/* testbench/spc_bank_sva.sv */
`timescale 1ns/1ps
module spc_bank_sva (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        mac_sync_lost,
	input wire logic        mac_cg_bad,
	input wire logic        mac_odd_start_inhibit,
	input wire logic        media_odd_start_inhibit,
	input wire logic        media_rx_invert,
	input wire logic        media_tx_invert,
	input wire logic        fx_force_hls,
	input wire logic        fx_fefi_on
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_wr(logic [7:0] a);
		psel && penable && pwrite && paddr == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	// mapped words run 0x40..0x64, aligned only
	wire bad = paddr < 8'h40 || paddr > 8'h64 || paddr[1:0] != 2'b00;
	chk_mac_odd_wr: assert property (
		s_wr(8'h40) |=> mac_odd_start_inhibit == $past(pwdata[2]))
		else $error("mac odd-start inhibit not written");
	chk_rx_pol_wr: assert property (
		s_wr(8'h5c) |=> media_rx_invert == $past(pwdata[6]))
		else $error("rx polarity not written");
	chk_tx_pol_wr: assert property (
		s_wr(8'h5c) |=> media_tx_invert == $past(pwdata[5]))
		else $error("tx polarity not written");
	chk_med_odd_wr: assert property (
		s_wr(8'h5c) |=> media_odd_start_inhibit == $past(pwdata[4]))
		else $error("media odd-start inhibit not written");
	chk_hls_wr: assert property (
		s_wr(8'h5c) |=> fx_force_hls == $past(pwdata[2]))
		else $error("force hls not written");
	chk_fefi_forced: assert property (
		s_wr(8'h5c) ##0 pwdata[1] |=> fx_fefi_on == $past(pwdata[0]))
		else $error("forced fefi value wrong");
	// a loss three edges back is already in the snapshot
	chk_sync_sticky: assert property (
		s_rd(8'h44) ##0 $past(mac_sync_lost, 3) |-> prdata[15])
		else $error("sync loss flag missing");
	chk_cg_sticky: assert property (
		s_rd(8'h44) ##0 $past(mac_cg_bad, 3) |-> prdata[14])
		else $error("bad code-group flag missing");
	chk_bad_addr: assert property (
		psel && penable && bad |-> pslverr)
		else $error("no error on unmapped address");
endmodule

/* testbench/spc_far.sv */
`timescale 1ns/1ps
module spc_far (
	input  wire logic        clk,
	output logic      [10:0] ev,
	output logic      [15:0] lv,
	output logic      [15:0] mv,
	output logic      [8:0]  ov,
	output logic      [15:0] wa,
	output logic      [15:0] wm,
	output logic      [15:0] wr
);
	initial
	begin
		{ev, lv, mv, wa, wm, wr} = '0;
		ov = 9'h010;
	end
	// events last one cycle, launched just after an edge
	task pulse(input logic [10:0] m, input int n);
		repeat (n)
		begin
			@(posedge clk) ev <= m;
			@(posedge clk) ev <= '0;
		end
	endtask
	task set(input logic [15:0] l, input logic [15:0] m, input logic [8:0] o);
		@(posedge clk);
		lv <= l;
		mv <= m;
		ov <= o;
	endtask
	task setw(input logic [15:0] a, input logic [15:0] m, input logic [15:0] r);
		@(posedge clk);
		wa <= a;
		wm <= m;
		wr <= r;
	endtask
endmodule

/* testbench/spc_bank_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) n_checks++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %h got %h", nm, e, g); end
module spc_bank_tb_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rq;
	logic        pready, pslverr, re;
	logic [15:0] mac_tx_code_word, media_tx_code_word, wa, wm, wr, lv, mv;
	logic        mac_odd_start_inhibit, media_odd_start_inhibit, media_pd_enable;
	logic        media_rx_invert, media_tx_invert, fx_force_hls, fx_fefi_on;
	logic [10:0] ev;
	logic [8:0]  ov;
	logic [7:0]  ac, aa;
	int          error_cnt = 0;
	int          n_checks = 0;
	int          i;
	always #5 clk = ~clk;
	spc_far spc_far_i (.clk, .ev, .lv, .mv, .ov, .wa, .wm, .wr);
	spc_bank spc_bank_i (
		.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.mac_sync_lost(ev[0]), .mac_cg_bad(ev[1]), .media_sync_lost(ev[2]),
		.media_cg_bad(ev[3]), .mac_comma_realign(ev[4]), .mac_serdes_sig_event(ev[5]),
		.mac_rx_code_valid(ev[6]), .media_tx_good(ev[7]), .media_tx_crc_err(ev[8]),
		.mac_tx_good(ev[9]), .mac_tx_crc_err(ev[10]), .mac_signal_detect(lv[0]),
		.mac_an_complete(lv[1]), .mac_link_up(lv[2]), .mac_lp_an_capable(lv[3]),
		.mac_adv_flags(lv[7:4]), .mac_remote_fault(lv[9:8]), .mac_lp_an_restart(lv[11]),
		.mac_align_error(lv[12]), .media_signal_detect(mv[0]), .media_an_complete(mv[1]),
		.media_link_up(mv[2]), .media_lp_an_capable(mv[3]), .media_lp_adv_flags(mv[7:4]),
		.media_lp_remote_fault(mv[9:8]), .media_lp_an_restart(mv[11]), .link_10(mv[12]),
		.fx_link_100(mv[13]), .mac_comma_position(ov[3:0]), .mac_comma_present(ov[4]),
		.mac_qsgmii_sync(ov[5]), .media_rf_sent(ov[7:6]), .media_fefi_auto(ov[8]),
		.mac_auto_code_word(wa), .media_auto_code_word(wm), .mac_rx_code_word(wr),
		.mac_tx_code_word, .media_tx_code_word, .mac_odd_start_inhibit,
		.media_odd_start_inhibit, .media_pd_enable, .media_rx_invert, .media_tx_invert,
		.fx_force_hls, .fx_fefi_on
	);
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK($sformatf("reg %h", a), e, rq)
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		// the tests need about 21000 cycles; 30000 leaves a safe margin
		#300000;
		error_cnt++;
		tally_and_finish;
	end
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rc(8'h48, 32'h0);
		rc(8'h64, 32'h0);
		rc(8'h5c, 32'h0010);
		`CHK("outs", 6'h30, {mac_odd_start_inhibit, media_odd_start_inhibit, media_pd_enable, media_rx_invert, media_tx_invert, fx_force_hls})
		for (i = 0; i < 4; i++)
		begin
			spc_far_i.set(16'h18a5 | 16'(i << 8), 16'h0, 9'h010);
			rc(8'h44, 32'h18a5 | (i << 8));
		end
		spc_far_i.set(16'h0, 16'h2a53, 9'h010);
		spc_far_i.pulse(11'h00f, 1);
		rc(8'h44, 32'hc000);
		rc(8'h44, 32'h0);
		rc(8'h60, 32'hea53);
		rc(8'h60, 32'h2a53);
		spc_far_i.set(16'h0, 16'h1a53, 9'h010);
		rc(8'h60, 32'h1a53);
		spc_far_i.set(16'h0, 16'h2a53, 9'h039);
		spc_far_i.pulse(11'h030, 1);
		rc(8'h50, 32'hf900);
		spc_far_i.set(16'h0, 16'h2a53, 9'h029);
		rc(8'h50, 32'h2900);
		spc_far_i.set(16'h0, 16'h2a53, 9'h039);
		rc(8'h50, 32'h2900);
		rc(8'h50, 32'h3900);
		spc_far_i.setw(16'h5a5a, 16'hc3c3, 16'hbeef);
		spc_far_i.pulse(11'h040, 1);
		spc_far_i.setw(16'h5a5a, 16'hc3c3, 16'h0123);
		rc(8'h4c, 32'hbeef);
		for (i = 0; i < 2; i++)
		begin
			ac = i ? 8'h5c : 8'h40;
			aa = i ? 8'h64 : 8'h48;
			apb(1'b1, aa, 32'h1111);
			rc(aa, i ? 32'hc3c3 : 32'h5a5a);
			// parallel detect stays clear: the control word written here leaves bit 13 at zero
			apb(1'b1, ac, i ? 32'h0810 : 32'h0804);
			apb(1'b1, aa, 32'h1111);
			rc(aa, 32'h1111);
			`CHK("txw", 16'h1111, i ? media_tx_code_word : mac_tx_code_word)
		end
		spc_far_i.set(16'h0, 16'h2a53, 9'h1b9);
		apb(1'b1, 8'h5c, 32'h0067);
		@(negedge clk);
		`CHK("ctl", 5'h1e, {media_rx_invert, media_tx_invert, fx_force_hls, fx_fefi_on, media_odd_start_inhibit})
		rc(8'h5c, 32'h8067);
		apb(1'b1, 8'h5c, 32'h0002);
		@(negedge clk);
		`CHK("fefi", 1'b0, fx_fefi_on)
		apb(1'b1, 8'h5c, 32'h0000);
		repeat (2) @(negedge clk);
		`CHK("fx", 3'h2, {fx_force_hls, fx_fefi_on, media_odd_start_inhibit})
		apb(1'b1, 8'h40, 32'h0);
		@(negedge clk);
		`CHK("odd", 1'b0, mac_odd_start_inhibit)
		spc_far_i.pulse(11'h080, 2);
		rc(8'h54, 32'h0);
		spc_far_i.set(16'h0, 16'h2a57, 9'h1b9);
		spc_far_i.pulse(11'h280, 3);
		rc(8'h54, 32'h8003);
		apb(1'b1, 8'h58, 32'h4000);
		spc_far_i.pulse(11'h200, 9996);
		rc(8'h54, 32'ha70f);
		spc_far_i.pulse(11'h280, 1);
		rc(8'h54, 32'h8000);
		spc_far_i.pulse(11'h400, 256);
		rc(8'h58, 32'h40ff);
		apb(1'b1, 8'h58, 32'h8000);
		spc_far_i.pulse(11'h780, 1);
		rc(8'h54, 32'h0);
		rc(8'h58, 32'h80ff);
		rc(8'h68, 32'h0);
		`CHK("err", 1'b1, re)
		apb(1'b1, 8'h45, 32'hffff);
		`CHK("err", 1'b1, re)
		tally_and_finish;
	end
endmodule
bind spc_bank spc_bank_sva spc_bank_sva_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pslverr, .mac_sync_lost, .mac_cg_bad, .mac_odd_start_inhibit,
	.media_odd_start_inhibit, .media_rx_invert, .media_tx_invert, .fx_force_hls, .fx_fefi_on);
